/* File: design/gpio_port.sv */
// How it works
// - Direction per pin is writable anytime; unassigned pins driven and sensed by port.
// - Set and clear strobes change only the masked output bits.
// - One word write loads the whole output value.
// - Per-pin read and per-pin write touch one pin only.
// - Each pin can interrupt on level, rising, falling or both edges.
// - Eight slots, each takes any pin, edge or level detection.
// - Two group units, each one combined interrupt from chosen pins.
// - Port interrupt raised by any enabled pin or set of pins.
// - After reset all pins except the debug-function pins are inputs and all interrupts are off.
// - Port unit drives one line built from several flags; slot line ORs edge flags with level-mode slot requests; group lines come from pin levels.
// - Per-pin configuration steers the pin mux to peripheral or port.
// - Each pin selects pull-up, pull-down or bus keeper.
// - Pseudo open-drain drives only low, otherwise releases.
// - Input inversion complements the sensed level before use.
// - Selected pins have a short glitch filter, off after reset.
// - Function select field picks peripheral or port function per pin.
// - After reset only debug pins select debug function, others default.
`timescale 1ns/1ps
module gpio_port #(
  parameter int NUM_PINS = 32
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // Port output control
  input wire logic dir_we_i,
  input wire logic [gpio_pkg::PORT_W-1:0] dir_data_i,
  input wire logic out_we_i,
  input wire logic [gpio_pkg::PORT_W-1:0] out_data_i,
  input wire logic set_we_i,
  input wire logic clr_we_i,
  input wire logic [gpio_pkg::PORT_W-1:0] mask_i,
  input wire logic pin_we_i,
  input wire logic [gpio_pkg::IDX_W-1:0] pin_idx_i,
  input wire logic pin_val_i,
  // Pin configuration
  input wire logic cfg_we_i,
  input wire logic [gpio_pkg::IDX_W-1:0] cfg_idx_i,
  input wire gpio_pkg::pin_cfg_t cfg_data_i,
  // Interrupt configuration and clearing
  input wire logic slot_we_i,
  input wire logic [2:0] slot_idx_i,
  input wire gpio_pkg::slot_cfg_t slot_data_i,
  input wire logic [gpio_pkg::SLOTS-1:0] slot_clr_i,
  input wire logic grp_we_i,
  input wire logic grp_idx_i,
  input wire gpio_pkg::grp_cfg_t grp_data_i,
  input wire logic port_en_we_i,
  input wire logic [gpio_pkg::PORT_W-1:0] port_en_data_i,
  input wire logic [gpio_pkg::PORT_W-1:0] port_clr_i,
  // Peripheral side
  input wire logic [gpio_pkg::PERIPH_FN-1:0][gpio_pkg::PORT_W-1:0] periph_out_i,
  input wire logic [gpio_pkg::PERIPH_FN-1:0][gpio_pkg::PORT_W-1:0] periph_oe_i,
  output logic [gpio_pkg::PORT_W-1:0] periph_in_o,
  // Pads
  input wire logic [gpio_pkg::PORT_W-1:0] pad_in_i,
  output logic [gpio_pkg::PORT_W-1:0] pad_out_o,
  output logic [gpio_pkg::PORT_W-1:0] pad_oe_o,
  output logic [gpio_pkg::PORT_W-1:0] pad_pu_o,
  output logic [gpio_pkg::PORT_W-1:0] pad_pd_o,
  output logic [gpio_pkg::PORT_W-1:0] pad_keep_o,
  output logic [gpio_pkg::PORT_W-1:0] pad_hyst_o,
  // Status
  output logic [gpio_pkg::PORT_W-1:0] in_o,
  output logic [gpio_pkg::PORT_W-1:0] out_val_o,
  output logic [gpio_pkg::PORT_W-1:0] dir_o,
  output logic pin_o,
  output logic [gpio_pkg::SLOTS-1:0] slot_flag_o,
  output logic [gpio_pkg::PORT_W-1:0] port_flag_o,
  // Interrupt lines
  output logic pint_irq_o,
  output logic [gpio_pkg::GROUPS-1:0] grp_irq_o,
  output logic port_irq_o
);
  import gpio_pkg::*;

  localparam int N = NUM_PINS;

  typedef struct packed {
    logic [N-1:0] dir;
    logic [N-1:0] out;
    pin_cfg_t [N-1:0] cfg;
    slot_cfg_t [SLOTS-1:0] slot;
    logic [SLOTS-1:0] slot_flag;
    grp_cfg_t [GROUPS-1:0] grp;
    logic [N-1:0] port_en;
    logic [N-1:0] port_flag;
    logic [N-1:0] prev;
    logic [N-1:0] in_q;
    logic pin_q;
    logic [N-1:0] pad_out;
    logic [N-1:0] pad_oe;
    logic [N-1:0] pad_pu;
    logic [N-1:0] pad_pd;
    logic [N-1:0] pad_keep;
    logic [N-1:0] pad_hyst;
    logic [N-1:0] periph_in;
    logic pint_irq;
    logic [GROUPS-1:0] grp_irq;
    logic port_irq;
  } port_state_t;

  port_state_t st;
  port_state_t next_st;
  logic [N-1:0] sense;
  logic [N-1:0] inv_v;
  logic [N-1:0] filt_v;

  initial begin
    if (NUM_PINS != PORT_W) begin
      $error("gpio_port: NUM_PINS must equal the package port width");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input conditioning

  always_comb begin
    for (int i = 0; i < N; i++) begin
      inv_v[i] = st.cfg[i].invert;
      filt_v[i] = st.cfg[i].filt_en;
    end
  end

  pin_conditioner #(
    .N(N),
    .FILTER_MASK(FILTER_PIN_MASK)
  ) u_cond (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .pad_in_i(pad_in_i),
    .inv_i(inv_v),
    .filt_en_i(filt_v),
    .sense_o(sense)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic pick(input logic [N-1:0] v, input logic [IDX_W-1:0] idx);
    pick = v[idx];
  endfunction

  function automatic logic [N-1:0] group_hit(input grp_cfg_t g, input logic [N-1:0] lvl);
    group_hit = g.en & ~(lvl ^ g.pol);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic [N-1:0] edge_v;
    logic [N-1:0] rise_v;
    logic [N-1:0] fall_v;
    logic [N-1:0] hit;
    logic [SLOTS-1:0] lvl_req;
    logic [SLOTS-1:0] slot_set;
    logic drv;
    logic val;
    logic s_lvl;
    logic s_rise;
    logic s_fall;
    logic [FUNCTION_SELECT_FIELD_W-1:0] fsel;
    edge_v = '0;
    rise_v = '0;
    fall_v = '0;
    hit = '0;
    lvl_req = '0;
    slot_set = '0;
    drv = 1'b0;
    val = 1'b0;
    s_lvl = 1'b0;
    s_rise = 1'b0;
    s_fall = 1'b0;
    fsel = FUNCTION_SELECT_FIELD_GPIO;
    next_st = st;

    // Output value writes, word first then masks then single pin
    next_st.dir = dir_we_i ? dir_data_i : st.dir;
    if (out_we_i) begin
      next_st.out = out_data_i;
    end
    if (set_we_i) begin
      next_st.out = next_st.out | mask_i;
    end
    if (clr_we_i) begin
      next_st.out = next_st.out & ~mask_i;
    end
    if (pin_we_i) begin
      next_st.out[pin_idx_i] = pin_val_i;
    end

    // Configuration writes
    if (cfg_we_i) begin
      next_st.cfg[cfg_idx_i] = cfg_data_i;
    end
    if (slot_we_i) begin
      next_st.slot[slot_idx_i] = slot_data_i;
    end
    if (grp_we_i) begin
      next_st.grp[grp_idx_i] = grp_data_i;
    end
    if (port_en_we_i) begin
      next_st.port_en = port_en_data_i;
    end

    // Edges from successive synchronised samples
    next_st.prev = sense;
    edge_v = sense ^ st.prev;
    rise_v = edge_v & sense;
    fall_v = edge_v & ~sense;

    // Pin interrupt slots
    for (int k = 0; k < SLOTS; k++) begin
      s_lvl = pick(sense, st.slot[k].pin);
      s_rise = pick(rise_v, st.slot[k].pin);
      s_fall = pick(fall_v, st.slot[k].pin);
      if (st.slot[k].level_mode) begin
        lvl_req[k] = (st.slot[k].en_hi & s_lvl) | (st.slot[k].en_lo & ~s_lvl);
      end else begin
        slot_set[k] = (st.slot[k].en_hi & s_rise) | (st.slot[k].en_lo & s_fall);
      end
    end
    next_st.slot_flag = (st.slot_flag & ~slot_clr_i) | slot_set;
    next_st.pint_irq = |(st.slot_flag | lvl_req);

    // Group interrupts
    for (int g = 0; g < GROUPS; g++) begin
      hit = group_hit(st.grp[g], sense);
      if (st.grp[g].and_mode) begin
        next_st.grp_irq[g] = (hit == st.grp[g].en) && (|st.grp[g].en);
      end else begin
        next_st.grp_irq[g] = |hit;
      end
    end

    // Port interrupt
    next_st.port_flag = (st.port_flag & ~port_clr_i) | (edge_v & st.port_en);
    next_st.port_irq = |st.port_flag;

    // Pin mux and pad controls
    for (int i = 0; i < N; i++) begin
      fsel = st.cfg[i].function_select_field;
      if (fsel == FUNCTION_SELECT_FIELD_GPIO) begin
        drv = st.dir[i];
        val = st.out[i];
        next_st.periph_in[i] = 1'b0;
      end else begin
        drv = periph_oe_i[fsel - 2'h1][i];
        val = periph_out_i[fsel - 2'h1][i];
        next_st.periph_in[i] = sense[i];
      end
      if (st.cfg[i].open_drain) begin
        next_st.pad_oe[i] = drv & ~val;
        next_st.pad_out[i] = 1'b0;
      end else begin
        next_st.pad_oe[i] = drv;
        next_st.pad_out[i] = val;
      end
      next_st.pad_pu[i] = st.cfg[i].pull == PULL_UP;
      next_st.pad_pd[i] = st.cfg[i].pull == PULL_DOWN;
      next_st.pad_keep[i] = st.cfg[i].pull == PULL_KEEP;
      next_st.pad_hyst[i] = st.cfg[i].hyst;
    end

    next_st.in_q = sense;
    next_st.pin_q = pick(sense, pin_idx_i);
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      st <= '0;
      for (int i = 0; i < N; i++) begin
        st.cfg[i].pull <= RST_PULL;
        if (DEBUG_PIN_MASK[i]) begin
          st.cfg[i].function_select_field <= FUNCTION_SELECT_FIELD_DEBUG;
        end
      end
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign periph_in_o = st.periph_in;
  assign pad_out_o = st.pad_out;
  assign pad_oe_o = st.pad_oe;
  assign pad_pu_o = st.pad_pu;
  assign pad_pd_o = st.pad_pd;
  assign pad_keep_o = st.pad_keep;
  assign pad_hyst_o = st.pad_hyst;
  assign in_o = st.in_q;
  assign out_val_o = st.out;
  assign dir_o = st.dir;
  assign pin_o = st.pin_q;
  assign slot_flag_o = st.slot_flag;
  assign port_flag_o = st.port_flag;
  assign pint_irq_o = st.pint_irq;
  assign grp_irq_o = st.grp_irq;
  assign port_irq_o = st.port_irq;

endmodule

/* File: design/pin_conditioner.sv */
`timescale 1ns/1ps
module pin_conditioner #(
  parameter int N = 32,
  parameter logic [31:0] FILTER_MASK = 32'h0000_0000
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // Pin levels and controls
  input wire logic [N-1:0] pad_in_i,
  input wire logic [N-1:0] inv_i,
  input wire logic [N-1:0] filt_en_i,
  // Conditioned level
  output logic [N-1:0] sense_o
);
  import gpio_pkg::*;

  typedef struct packed {
    logic [N-1:0] s1;
    logic [N-1:0] s2;
    logic [N-1:0] s3;
    logic [N-1:0] filt;
    logic [N-1:0] sense;
  } cond_state_t;

  cond_state_t st;
  cond_state_t next_st;

  initial begin
    if (FILT_CYC != 1 || N > 32) begin
      $error("pin_conditioner: unsupported filter length or width");
    end
  end

  always_comb begin
    next_st = st;
    next_st.s1 = pad_in_i;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    for (int i = 0; i < N; i++) begin
      // Accept a level only after two agreeing samples
      if (st.s2[i] == st.s3[i]) begin
        next_st.filt[i] = st.s2[i];
      end
      if (filt_en_i[i] && FILTER_MASK[i]) begin
        next_st.sense[i] = st.filt[i] ^ inv_i[i];
      end else begin
        next_st.sense[i] = st.s2[i] ^ inv_i[i];
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sense_o = st.sense;

endmodule

/* File: shared/gpio_pkg.sv */
package gpio_pkg;

  // Port shape
  localparam int PORT_W = 32;
  localparam int IDX_W = 5;
  localparam int SLOTS = 8;
  localparam int GROUPS = 2;
  localparam int PERIPH_FN = 3;
  localparam int FUNCTION_SELECT_FIELD_W = 2;

  // Function select codes
  localparam logic [FUNCTION_SELECT_FIELD_W-1:0] FUNCTION_SELECT_FIELD_GPIO = 2'h0;
  localparam logic [FUNCTION_SELECT_FIELD_W-1:0] FUNCTION_SELECT_FIELD_DEBUG = 2'h1;

  // Pull modes
  localparam logic [1:0] PULL_NONE = 2'h0;
  localparam logic [1:0] PULL_DOWN = 2'h1;
  localparam logic [1:0] PULL_UP = 2'h2;
  localparam logic [1:0] PULL_KEEP = 2'h3;

  // Reset values
  localparam logic [PORT_W-1:0] DEBUG_PIN_MASK = 32'h0000_fc00;
  localparam logic [PORT_W-1:0] FILTER_PIN_MASK = 32'h00c1_f800;
  localparam logic [1:0] RST_PULL = PULL_UP;

  // Glitch filter timing
  localparam int CLK_MHZ = 40;
  localparam int FILT_NS = 10;
  localparam int FILT_CYC_RAW = (FILT_NS * CLK_MHZ + 999) / 1000;
  localparam int FILT_CYC = (FILT_CYC_RAW < 1) ? 1 : FILT_CYC_RAW;

  typedef struct packed {
    logic [FUNCTION_SELECT_FIELD_W-1:0] function_select_field;
    logic [1:0] pull;
    logic open_drain;
    logic invert;
    logic filt_en;
    logic hyst;
  } pin_cfg_t;

  typedef struct packed {
    logic [IDX_W-1:0] pin;
    logic level_mode;
    logic en_hi;
    logic en_lo;
  } slot_cfg_t;

  typedef struct packed {
    logic [PORT_W-1:0] en;
    logic [PORT_W-1:0] pol;
    logic and_mode;
  } grp_cfg_t;

endpackage

/* File: sim/gpio_port_properties.sv */
`timescale 1ns/1ps
module port_props (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // Writes
  input wire logic dir_we_i,
  input wire logic [gpio_pkg::PORT_W-1:0] dir_data_i,
  input wire logic out_we_i,
  input wire logic [gpio_pkg::PORT_W-1:0] out_data_i,
  input wire logic set_we_i,
  input wire logic clr_we_i,
  input wire logic [gpio_pkg::PORT_W-1:0] mask_i,
  input wire logic pin_we_i,
  input wire logic [gpio_pkg::IDX_W-1:0] pin_idx_i,
  input wire logic pin_val_i,
  input wire logic port_en_we_i,
  input wire logic [gpio_pkg::PORT_W-1:0] port_clr_i,
  // Outputs
  input wire logic [gpio_pkg::PORT_W-1:0] dir_o,
  input wire logic [gpio_pkg::PORT_W-1:0] out_val_o,
  input wire logic [gpio_pkg::PORT_W-1:0] pad_oe_o,
  input wire logic [gpio_pkg::SLOTS-1:0] slot_flag_o,
  input wire logic [gpio_pkg::PORT_W-1:0] port_flag_o,
  input wire logic pint_irq_o,
  input wire logic port_irq_o
);
  import gpio_pkg::*;
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (srst_i);
  logic [3:0] ops;
  assign ops = {out_we_i, set_we_i, clr_we_i, pin_we_i};
  ////////////////////////////////////////
  a_dir_load: assert property (dir_we_i |=> dir_o == $past(dir_data_i))
    else $error("direction not loaded");
  a_word_load: assert property (ops == 4'b1000 |=> out_val_o == $past(out_data_i))
    else $error("output word not loaded");
  a_set_bits: assert property (ops == 4'b0100 |=>
    out_val_o == ($past(out_val_o) | $past(mask_i)))
    else $error("set strobe wrong");
  a_clear_bits: assert property (ops == 4'b0010 |=>
    out_val_o == ($past(out_val_o) & ~$past(mask_i)))
    else $error("clear strobe wrong");
  a_pin_write: assert property (ops == 4'b0001 |=> out_val_o ==
    ($past(out_val_o) & ~(32'h1 << $past(pin_idx_i)) | ({31'h0, $past(pin_val_i)} << $past(pin_idx_i))))
    else $error("pin write wrong");
  a_reset_idle: assert property ($fell(srst_i) |->
    dir_o == '0 && pad_oe_o == '0 && slot_flag_o == '0 && !pint_irq_o)
    else $error("not idle after reset");
  a_pint_line: assert property (|slot_flag_o |=> pint_irq_o)
    else $error("pin interrupt line low");
  a_port_line: assert property (|port_flag_o |=> port_irq_o)
    else $error("port interrupt line low");
  a_flag_hold: assert property (!port_en_we_i |=>
    ($past(port_flag_o) & ~$past(port_clr_i) & ~port_flag_o) == '0)
    else $error("port flag dropped");
endmodule
bind gpio_port port_props chk (
  .ref_clk_i(ref_clk_i), .srst_i(srst_i), .dir_we_i(dir_we_i), .dir_data_i(dir_data_i),
  .out_we_i(out_we_i), .out_data_i(out_data_i), .set_we_i(set_we_i), .clr_we_i(clr_we_i),
  .mask_i(mask_i), .pin_we_i(pin_we_i), .pin_idx_i(pin_idx_i), .pin_val_i(pin_val_i),
  .port_en_we_i(port_en_we_i), .port_clr_i(port_clr_i), .dir_o(dir_o),
  .out_val_o(out_val_o), .pad_oe_o(pad_oe_o), .slot_flag_o(slot_flag_o),
  .port_flag_o(port_flag_o), .pint_irq_o(pint_irq_o), .port_irq_o(port_irq_o)
);

/* File: sim/pad_model.sv */
`timescale 1ns/1ps
module pad_model (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // Device pad controls
  input wire logic [31:0] pad_out_i,
  input wire logic [31:0] pad_oe_i,
  input wire logic [31:0] pad_pu_i,
  input wire logic [31:0] pad_pd_i,
  input wire logic [31:0] pad_keep_i,
  // Outside drivers
  input wire logic [31:0] ext_en_i,
  input wire logic [31:0] ext_val_i,
  // Resolved level
  output logic [31:0] pad_o
);
  logic [31:0] last;
  logic wig;
  always_ff @(posedge ref_clk_i) begin
    last <= srst_i ? '0 : pad_o;
    wig <= srst_i ? 1'b0 : ~wig;
  end
  // Floating pin wanders every cycle
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      if (pad_oe_i[i]) begin
        pad_o[i] = pad_out_i[i];
      end else if (ext_en_i[i]) begin
        pad_o[i] = ext_val_i[i];
      end else if (pad_pu_i[i] | pad_pd_i[i] | pad_keep_i[i]) begin
        pad_o[i] = pad_pu_i[i] | (pad_keep_i[i] & last[i]);
      end else begin
        pad_o[i] = wig;
      end
    end
  end
endmodule

/* File: sim/tb_gpio_port_with_pin_config.sv */
`timescale 1ns/1ps
module tb_gpio_port_with_pin_config;
  import gpio_pkg::*;
  logic ref_clk_i, srst_i, pv, pino, pirq, qirq;
  logic [8:0] we;
  logic [4:0] idx;
  logic [7:0] sclr, sflag;
  logic [1:0] girq;
  logic [31:0] d, een, ev, pclr, pads, pin_in, pout, poeo, pu, pd, kp, hy, ino, outv, dir, pflag;
  logic [2:0][31:0] po, poe;
  pin_cfg_t cfg;
  slot_cfg_t sc;
  grp_cfg_t gc;
  int errors, samples_checked;
  gpio_port uut (
    .ref_clk_i(ref_clk_i), .srst_i(srst_i), .dir_we_i(we[0]), .dir_data_i(d),
    .out_we_i(we[1]), .out_data_i(d), .set_we_i(we[2]), .clr_we_i(we[3]), .mask_i(d),
    .pin_we_i(we[4]), .pin_idx_i(idx), .pin_val_i(pv), .cfg_we_i(we[5]), .cfg_idx_i(idx),
    .cfg_data_i(cfg), .slot_we_i(we[6]), .slot_idx_i(idx[2:0]), .slot_data_i(sc),
    .slot_clr_i(sclr), .grp_we_i(we[7]), .grp_idx_i(idx[0]), .grp_data_i(gc),
    .port_en_we_i(we[8]), .port_en_data_i(d), .port_clr_i(pclr), .periph_out_i(po),
    .periph_oe_i(poe), .periph_in_o(pin_in), .pad_in_i(pads), .pad_out_o(pout),
    .pad_oe_o(poeo), .pad_pu_o(pu), .pad_pd_o(pd), .pad_keep_o(kp), .pad_hyst_o(hy),
    .in_o(ino), .out_val_o(outv), .dir_o(dir), .pin_o(pino), .slot_flag_o(sflag),
    .port_flag_o(pflag), .pint_irq_o(pirq), .grp_irq_o(girq), .port_irq_o(qirq)
  );
  pad_model far (
    .ref_clk_i(ref_clk_i), .srst_i(srst_i), .pad_out_i(pout), .pad_oe_i(poeo),
    .pad_pu_i(pu), .pad_pd_i(pd), .pad_keep_i(kp), .ext_en_i(een), .ext_val_i(ev),
    .pad_o(pads)
  );
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask
  task automatic go(input int k);
    we[k] = 1'b1;
    tick(1);
    we = '0;
  endtask
  task automatic sclear();
    sclr = '1;
    tick(1);
    sclr = '0;
    chk(sflag, '0);
  endtask
  task automatic results();
    if (errors == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    errors = 0;
    samples_checked = 0;
    {srst_i, pv, we, idx, sclr, d, een, ev, pclr, po, poe, cfg, sc, gc} = '0;
    srst_i = 1'b1;
    tick(5);
    srst_i = 1'b0;
    tick(8);
    chk(dir, '0);
    chk(poeo, '0);
    chk({sflag, pirq, girq, qirq}, '0);
    chk(pu, '1);
    chk(pin_in, DEBUG_PIN_MASK);
    chk(ino, '1);
    d = 32'h00ff_00ff;
    go(0);
    d = 32'h1234_5678;
    go(1);
    chk(outv, 32'h1234_5678);
    d = 32'h0000_0f0f;
    go(2);
    chk(outv, 32'h1234_5f7f);
    d = 32'h0000_7f00;
    go(3);
    chk(outv, 32'h1234_007f);
    idx = 5'd31;
    pv = 1'b1;
    go(4);
    chk(outv, 32'h9234_007f);
    tick(2);
    chk(poeo, 32'h00ff_00ff);
    chk(pout & poeo, 32'h0034_007f);
    tick(4);
    chk(ino, 32'hff34_ff7f);
    idx = 5'd0;
    cfg.pull = PULL_UP;
    cfg.open_drain = 1'b1;
    go(5);
    tick(3);
    chk(poeo[0], 1'b0);
    d = 32'h1;
    go(3);
    tick(2);
    chk({poeo[0], pout[0]}, 2'b10);
    idx = 5'd24;
    for (int m = 0; m < 4; m++) begin
      cfg = '0;
      cfg.pull = m[1:0];
      cfg.hyst = m[0];
      go(5);
      tick(2);
      chk({kp[24], pd[24], pu[24], hy[24]}, {m == 3, m == 1, m == 2, m[0]});
    end
    idx = 5'd25;
    cfg = '0;
    cfg.pull = PULL_UP;
    cfg.invert = 1'b1;
    go(5);
    tick(7);
    chk({ino[25], pino}, 2'b00);
    idx = 5'd26;
    for (int f = 1; f <= PERIPH_FN; f++) begin
      cfg = '0;
      cfg.function_select_field = f[1:0];
      cfg.pull = PULL_DOWN;
      go(5);
      poe[f-1][26] = 1'b1;
      po[f-1][26] = 1'b1;
      tick(3);
      chk({poeo[26], pout[26]}, 2'b11);
      tick(4);
      chk(pin_in[26], 1'b1);
      poe = '0;
      po = '0;
      tick(7);
      chk(pin_in[26], 1'b0);
    end
    d = 32'h0000_00ff;
    go(0);
    een = 32'h0030_0000;
    tick(8);
    idx = 5'd7;
    for (int m = 1; m < 4; m++) begin
      sc = '0;
      sc.pin = 5'd20;
      sc.en_hi = m[0];
      sc.en_lo = m[1];
      go(6);
      sclear();
      ev[20] = 1'b1;
      tick(8);
      chk({sflag[7], pirq}, {2{m[0]}});
      sclear();
      ev[20] = 1'b0;
      tick(8);
      chk({sflag[7], pirq}, {2{m[1]}});
    end
    sc.level_mode = 1'b1;
    sc.en_hi = 1'b1;
    sc.en_lo = 1'b0;
    go(6);
    sclear();
    ev[20] = 1'b1;
    tick(8);
    chk(pirq, 1'b1);
    ev[20] = 1'b0;
    tick(8);
    chk(pirq, 1'b0);
    gc.en = 32'h0030_0000;
    gc.pol = 32'h0030_0000;
    gc.and_mode = 1'b1;
    idx = 5'd1;
    go(7);
    d = 32'h0020_0000;
    go(8);
    ev[20] = 1'b1;
    tick(8);
    chk(girq, 2'b00);
    ev[21] = 1'b1;
    tick(8);
    chk(girq, 2'b10);
    chk(pflag, 32'h0020_0000);
    chk(qirq, 1'b1);
    pclr = 32'h0020_0000;
    tick(1);
    pclr = '0;
    chk(pflag, '0);
    // Group 0 in any-pin mode, active low
    gc.and_mode = 1'b0;
    gc.pol = '0;
    idx = 5'd0;
    go(7);
    tick(6);
    chk(girq, 2'b10);
    ev[21] = 1'b0;
    tick(8);
    chk(girq, 2'b01);
    idx = 5'd22;
    cfg = '0;
    cfg.pull = PULL_UP;
    cfg.filt_en = 1'b1;
    go(5);
    een[22] = 1'b1;
    ev[22] = 1'b1;
    tick(8);
    ev[22] = 1'b0;
    tick(1);
    ev[22] = 1'b1;
    repeat (8) begin
      tick(1);
      chk(ino[22], 1'b1);
    end
    results();
  end
endmodule
